// file: common/spi_prot_pkg.sv
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
package spi_prot_pkg;
   localparam logic [7:0]  op_write         = 8'h02;
   localparam logic [7:0]  op_status_write  = 8'h01;
   localparam logic [7:0]  op_set_latch     = 8'h06;
   localparam logic [7:0]  op_clear_latch   = 8'h04;
   localparam logic [2:0]  bit_last         = 3'h7;
   localparam logic [13:0] addr_mask        = 14'h3fff;
   localparam logic [1:0]  addr_bytes       = 2'h2;
   localparam int          clk_mhz          = 100;
   localparam int          power_up_read_delay_us  = 10;
   localparam int          power_up_write_delay_us = 10;
   localparam int          power_up_cycles = power_up_write_delay_us * clk_mhz;
   localparam logic [10:0] power_up_count  = 11'(power_up_cycles);

   typedef enum logic [2:0] {
      st_opcode,
      st_addr,
      st_data,
      st_status,
      st_ignore
   } cmd_state_t;

   typedef struct packed {
      logic        valid;
      logic [13:0] addr;
      logic [7:0]  data;
   } byte_req_t;

   typedef struct packed {
      logic       valid;
      logic       memory;
      logic [6:0] bytes;
      logic [7:0] status;
   } commit_t;
endpackage

// file: rtl/spi_eeprom_hold_protect.sv
module spi_eeprom_hold_protect
   import spi_prot_pkg::*;
(
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      reset_n,
   // Serial pins
   input  wire logic      cs_n,
   input  wire logic      sck,
   input  wire logic      si,
   input  wire logic      hold_n,
   output logic           so,
   output logic           so_oe,
   // Write-protect pin and status protect bit
   input  wire logic      wp_n,
   input  wire logic      status_protect,
   // Memory side
   output byte_req_t      load,
   output commit_t        commit,
   output logic           write_latch,
   output logic           power_ready,
   output logic           suspended
);
   cmd_state_t  state;
   cmd_state_t  next_state;
   logic        sck_q;
   logic        cs_q;
   logic [2:0]  bitcnt;
   logic [2:0]  next_bitcnt;
   logic [7:0]  shreg;
   logic [7:0]  next_shreg;
   logic [1:0]  addr_cnt;
   logic [1:0]  next_addr_cnt;
   logic [15:0] addr;
   logic [15:0] next_addr;
   logic [6:0]  nbytes;
   logic [6:0]  next_nbytes;
   logic        is_write;
   logic        next_is_write;
   logic        next_latch;
   logic [10:0] pu_cnt;
   logic [10:0] next_pu_cnt;
   byte_req_t   next_load;
   commit_t     next_commit;
   logic        rise;
   logic        cs_rise;
   logic [7:0]  rx;

   suspend_ctl u_suspend (
      .clk       (clk),
      .reset_n   (reset_n),
      .cs_n      (cs_n),
      .sck       (sck),
      .hold_n    (hold_n),
      .suspended (suspended)
   );

   // Clock edges are ignored while suspended, so the bit position is kept
   assign rise    = sck && !sck_q && !cs_n && !suspended;
   assign cs_rise = cs_n && !cs_q;
   assign rx      = {shreg[6:0], si};
   // No read path lives here: the output stays released, always so in suspend
   assign so      = 1'b0;
   assign so_oe   = 1'b0;

   //---------------------------------------------------------------------------
   // Power-up wait
   //---------------------------------------------------------------------------
   always_comb begin
      next_pu_cnt = pu_cnt;
      if (pu_cnt != power_up_count) begin
         next_pu_cnt = pu_cnt + 11'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pu_cnt      <= 11'h0;
         power_ready <= 1'b0;
      end else begin
         pu_cnt      <= next_pu_cnt;
         power_ready <= (next_pu_cnt == power_up_count);
      end
   end

   //---------------------------------------------------------------------------
   // Command decoder
   //---------------------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_bitcnt   = bitcnt;
      next_shreg    = shreg;
      next_addr_cnt = addr_cnt;
      next_addr     = addr;
      next_nbytes   = nbytes;
      next_is_write = is_write;
      next_latch    = write_latch;
      next_load     = '0;
      next_commit   = '0;
      if (cs_n) begin
         // Select high resets the serial logic; writes commit only on boundary
         if (cs_rise && bitcnt == 3'h0 && power_ready && write_latch) begin
            if (state == st_data && nbytes != 7'h0) begin
               next_commit.valid  = 1'b1;
               next_commit.memory = 1'b1;
               next_commit.bytes  = nbytes;
               next_latch         = 1'b0;
            end else if (state == st_ignore && is_write && nbytes == 7'h1) begin
               next_commit.valid  = 1'b1;
               next_commit.status = shreg;
               next_latch         = 1'b0;
            end
         end
         next_state    = st_opcode;
         next_bitcnt   = 3'h0;
         next_addr_cnt = 2'h0;
         next_nbytes   = 7'h0;
         next_is_write = 1'b0;
      end else if (rise) begin
         next_shreg  = rx;
         next_bitcnt = bitcnt + 3'h1;
         if (bitcnt == bit_last) begin
            unique case (state)
               st_opcode: begin
                  if (rx == op_set_latch && power_ready) begin
                     next_latch = 1'b1;
                     next_state = st_ignore;
                  end else if (rx == op_clear_latch) begin
                     next_latch = 1'b0;
                     next_state = st_ignore;
                  end else if (rx == op_write && write_latch) begin
                     next_state = st_addr;
                  end else if (rx == op_status_write && write_latch
                               && (wp_n || !status_protect)) begin
                     next_state = st_status;
                  end else begin
                     next_state = st_ignore;
                  end
               end
               st_addr: begin
                  next_addr     = {addr[7:0], rx};
                  next_addr_cnt = addr_cnt + 2'h1;
                  if (addr_cnt + 2'h1 == addr_bytes) begin
                     next_state = st_data;
                  end
               end
               st_data: begin
                  next_load.valid = 1'b1;
                  next_load.addr  = addr[13:0] & addr_mask;
                  next_load.data  = rx;
                  next_addr       = addr + 16'h1;
                  if (nbytes != 7'h7f) begin
                     next_nbytes = nbytes + 7'h1;
                  end
               end
               st_status: begin
                  next_is_write = 1'b1;
                  next_nbytes   = 7'h1;
                  next_state    = st_ignore;
               end
               st_ignore: begin
                  if (is_write) begin
                     next_nbytes = 7'h2;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state       <= st_opcode;
         sck_q       <= 1'b0;
         cs_q        <= 1'b1;
         bitcnt      <= 3'h0;
         shreg       <= 8'h0;
         addr_cnt    <= 2'h0;
         addr        <= 16'h0;
         nbytes      <= 7'h0;
         is_write    <= 1'b0;
         write_latch <= 1'b0;
         load        <= '0;
         commit      <= '0;
      end else begin
         state       <= next_state;
         sck_q       <= sck;
         cs_q        <= cs_n;
         bitcnt      <= next_bitcnt;
         shreg       <= next_shreg;
         addr_cnt    <= next_addr_cnt;
         addr        <= next_addr;
         nbytes      <= next_nbytes;
         is_write    <= next_is_write;
         write_latch <= next_latch;
         load        <= next_load;
         commit      <= next_commit;
      end
   end

   // Select rising during suspend resets the counter, which is not a shift
   no_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
      (suspended && !cs_n) |=> $stable(bitcnt)) else $error("bits shifted in suspend");
   pu_block_a: assert property (@(posedge clk) disable iff (!reset_n)
      !power_ready |-> !next_commit.valid) else $error("write before power up");
   boundary_a: assert property (@(posedge clk) disable iff (!reset_n)
      (cs_rise && bitcnt != 3'h0) |=> !commit.valid)
      else $error("write off bus boundary");
   latch_a: assert property (@(posedge clk) disable iff (!reset_n)
      commit.valid |-> !write_latch) else $error("latch not cleared");
   two_byte_a: assert property (@(posedge clk) disable iff (!reset_n)
      (commit.valid && !commit.memory) |-> commit.bytes == 7'h0)
      else $error("status commit carries length");
   long_status_a: assert property (@(posedge clk) disable iff (!reset_n)
      (cs_rise && is_write && nbytes == 7'h2) |=> !commit.valid)
      else $error("long status write accepted");
   addr_mask_a: assert property (@(posedge clk) disable iff (!reset_n)
      load.valid |-> load.addr <= addr_mask) else $error("high address bits used");
   set_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
      (rise && bitcnt == bit_last && state == st_opcode && rx == op_set_latch
       && power_ready) |=> write_latch) else $error("latch not set");
   so_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      suspended |-> !so_oe) else $error("output driven in suspend");
endmodule

// file: rtl/suspend_ctl.sv
module suspend_ctl
   import spi_prot_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Pins, sampled
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic hold_n,
   // State
   output logic      suspended
);
   logic hold_q;
   logic next_hold_q;
   logic next_suspended;

   always_comb begin
      next_hold_q    = hold_n;
      next_suspended = suspended;
      if (cs_n) begin
         next_suspended = 1'b0;
      end else if (hold_q && !hold_n && !sck) begin
         next_suspended = 1'b1;
      end else if (!hold_q && hold_n) begin
         next_suspended = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hold_q    <= 1'b1;
         suspended <= 1'b0;
      end else begin
         hold_q    <= next_hold_q;
         suspended <= next_suspended;
      end
   end

   sel_ends_a: assert property (@(posedge clk) disable iff (!reset_n)
      cs_n |=> !suspended) else $error("suspend survived select high");
   enter_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!cs_n && hold_q && !hold_n && !sck) |=> suspended)
      else $error("suspend not entered");
   leave_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!cs_n && !hold_q && hold_n) |=> !suspended)
      else $error("suspend not left");
endmodule

// file: test/spi_eeprom_hold_protect_test.sv
module spi_eeprom_hold_protect_test;
   import spi_prot_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic      clk, reset_n, wp_n, status_protect;
   logic      cs_n, sck, si, hold_n, so, so_oe;
   logic      write_latch, power_ready, suspended;
   byte_req_t load, last_l;
   commit_t   commit, last_c;
   int        bad_count, comparisons, n_c, n_l, c, l;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));

   spi_eeprom_hold_protect dut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck),
      .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe), .wp_n(wp_n),
      .status_protect(status_protect), .load(load), .commit(commit),
      .write_latch(write_latch), .power_ready(power_ready), .suspended(suspended));

   // Pulses last one cycle, so they are captured here
   always @(posedge clk) begin
      if (commit.valid === 1'b1) begin
         n_c++;
         last_c = commit;
      end
      if (load.valid === 1'b1) begin
         n_l++;
         last_l = load;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input logic [7:0] op, input logic [7:0] d, input int n);
      host.sel(1'b0);
      host.bits(op, 8);
      repeat (n) host.bits(d, 8);
      host.sel(1'b1);
      host.step(2);
   endtask

   task automatic latch_on;
      wr(op_set_latch, 8'h00, 0);
   endtask

   task automatic t_power;
      int i;
      latch_on();
      check("early latch", write_latch, 0);
      for (i = 0; i < 1100 && power_ready !== 1'b1; i++)
         @(negedge clk);
      check("power ready", power_ready, 1);
      if (power_ready !== 1'b1)
         tally_and_finish();
   endtask

   task automatic t_status;
      c = n_c;
      wr(op_status_write, 8'ha5, 1);
      check("no latch", n_c, c);
      latch_on();
      check("latch set", write_latch, 1);
      wp_n = 1'b0;
      status_protect = 1'b1;
      wr(op_status_write, 8'ha5, 1);
      check("protected", n_c, c);
      wp_n = 1'b1;
      wr(op_status_write, 8'ha5, 2);
      check("long status", n_c, c);
      check("latch kept", write_latch, 1);
      // Pin low with the protect bit clear must still accept the write
      wp_n = 1'b0;
      status_protect = 1'b0;
      wr(op_status_write, 8'ha5, 1);
      wp_n = 1'b1;
      check("status commit", n_c, c + 1);
      check("status value", {last_c.memory, last_c.status}, 9'h0a5);
      check("latch cleared", write_latch, 0);
   endtask

   task automatic t_partial;
      c = n_c;
      l = n_l;
      latch_on();
      host.sel(1'b0);
      host.bits(op_write, 8);
      repeat (2) host.bits(8'hff, 8);
      host.bits(8'h3c, 8);
      host.bits(8'h80, 3);
      host.sel(1'b1);
      host.step(2);
      check("load count", n_l, l + 1);
      check("load word", {last_l.addr, last_l.data}, 22'h3fff3c);
      check("partial", n_c, c);
      check("latch kept", write_latch, 1);
   endtask

   task automatic t_suspend;
      host.sel(1'b0);
      host.bits(op_write, 8);
      host.bits(8'hc0, 8);
      host.bits(8'h12, 8);
      host.bits(8'h96, 4);
      host.hold(1'b0);
      check("held", suspended, 1);
      check("out released", so_oe, 0);
      host.bits(8'hff, 4);
      host.hold(1'b1);
      check("resumed", suspended, 0);
      host.bits(8'h60, 4);
      check("load word", {last_l.addr, last_l.data}, 22'h001296);
      host.bits(8'h5a, 8);
      host.sel(1'b1);
      host.step(2);
      check("page commit", {last_c.memory, last_c.bytes}, 8'h82);
   endtask

   task automatic t_select_end;
      host.hold(1'b0);
      check("idle hold", suspended, 0);
      host.hold(1'b1);
      host.sel(1'b0);
      host.bits(8'h00, 3);
      host.hold(1'b0);
      check("held", suspended, 1);
      host.sel(1'b1);
      check("select ends", suspended, 0);
      host.hold(1'b1);
      latch_on();
      check("logic reset", write_latch, 1);
      c = n_c;
      wr(op_clear_latch, 8'h00, 0);
      check("latch off", write_latch, 0);
      wr(op_status_write, 8'h3c, 1);
      check("refused", n_c, c);
   endtask

   initial begin
      reset_n = 1'b0;
      wp_n = 1'b1;
      status_protect = 1'b0;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      t_power();
      t_status();
      t_partial();
      t_suspend();
      t_select_end();
      tally_and_finish();
   end
endmodule

// file: test/spi_host_model.sv
module spi_host_model (
   // Clock
   input  wire logic clk,
   // Serial pins toward the device
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   output logic      hold_n
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cs_n   = 1'b1;
      sck    = 1'b0;
      si     = 1'b0;
      hold_n = 1'b1;
   end

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic sel(input logic b);
      step(1);
      cs_n = b;
      // A released data line must not keep showing its last bit
      if (b)
         si = ~si;
      step(2);
   endtask

   // MSB first, data set up while the clock is low
   task automatic bits(input logic [7:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         si = v[7-i];
         step(2);
         sck = 1'b1;
         step(2);
         sck = 1'b0;
      end
   endtask

   task automatic hold(input logic b);
      step(1);
      hold_n = b;
      step(2);
   endtask
endmodule
